//--- logic/cdc_core.v
// Overview of operation
// - optional clocks kept running in stop for wakeup
// - debug enable keeps oscillator running in stop
// - background command wakes stopped core into background
// - background opcode halts until reset or resume
// - background opcode anywhere acts as breakpoint
// - flag layout V7 H4 I3 N2 Z1 C0
// - carry is carry out of bit 7
// - 16-bit memory operands are big-endian
// - page-zero address has zero high byte
// - full address follows opcode high byte first
// - branch adds signed offset to next address
// - index and stack offset address forms
// - 16-bit offset addition wraps in 64 KB
// - post-increment modes only for compare and copy
// - add with carry opcodes and operation
// - add opcodes, flags updated, mask kept
// - stack adjust adds signed byte, flags kept
// - index adjust adds signed byte, flags kept
// - and clears V, sets N Z, keeps H C
// - literal 2, page-zero 3, full 4 cycles
`timescale 1ns/1ns
`default_nettype none
`include "cdc_core_regs.vh"

module cdc_core (
  input wire clk,
  input wire rst_b,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [15:0] mem_addr,
  output wire mem_rd,
  input wire [7:0] mem_rdata,
  input wire bg_strap,
  input wire wake_tick,
  input wire ext_wake,
  input wire dbg_bg_cmd,
  input wire dbg_go_cmd,
  input wire dbg_step_cmd,
  input wire dbg_tag_cmd,
  output wire osc_run,
  output wire core_clk_en,
  output wire bg_active
);

  localparam S_FETCH = 5'b00001;
  localparam S_ADR1 = 5'b00010;
  localparam S_ADR2 = 5'b00100;
  localparam S_READ = 5'b01000;
  localparam S_IDLE = 5'b10000;

  reg [4:0] state_reg;
  reg [15:0] pc_reg;
  reg [7:0] acc_reg;
  reg [15:0] hx_reg;
  reg [15:0] stack_ptr_reg;
  reg [7:0] flags_reg;
  reg [7:0] op_reg;
  reg pfx_reg;
  reg [7:0] ea_hi_reg;
  reg dbg_en_reg;
  reg keep_clk_reg;
  reg stopped_reg;
  reg stop_pend_reg;
  reg bg_reg;
  reg ill_reg;
  reg boot_reg;
  reg step_pend_reg;
  reg began_reg;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // {flags, result}; flags merged with old so untouched bits survive
  function [15:0] alu;
    input [3:0] kind;
    input [7:0] a;
    input [7:0] m;
    input [7:0] f;
    reg [8:0] sum;
    reg [4:0] low;
    reg [7:0] r;
    reg [7:0] nf;
    begin
      sum = {1'b0, a} + {1'b0, m} + {8'h00, (kind == `CDC_LO_ADC) & f[`CDC_F_C]};
      low = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, (kind == `CDC_LO_ADC) & f[`CDC_F_C]};
      nf = f;
      if (kind == `CDC_LO_AND) begin
        r = a & m;
        nf[`CDC_F_V] = 1'b0;
      end else begin
        r = sum[7:0];
        nf[`CDC_F_V] = (a[7] == m[7]) && (r[7] != a[7]);
        nf[`CDC_F_H] = low[4];
        nf[`CDC_F_C] = sum[8];
      end
      nf[`CDC_F_N] = r[7];
      nf[`CDC_F_Z] = (r == 8'h00);
      alu = {nf, r};
    end
  endfunction

  // 16-bit add that wraps, so signed and unsigned offsets agree
  function [15:0] wadd;
    input [15:0] base;
    input [15:0] off;
    begin
      wadd = base + off;
    end
  endfunction

  function [15:0] sext;
    input [7:0] b;
    begin
      sext = {{8{b[7]}}, b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the byte on the bus and of the held opcode

  wire [3:0] cur_hi = mem_rdata[7:4];
  wire [3:0] cur_lo = mem_rdata[3:0];
  wire cur_alu = (cur_lo == `CDC_LO_ADC) || (cur_lo == `CDC_LO_ADD) ||
    (cur_lo == `CDC_LO_AND);
  wire cur_branch = (mem_rdata == `CDC_OP_BCC) || (mem_rdata == `CDC_OP_BCS) ||
    (mem_rdata == `CDC_OP_BEQ);
  wire cur_adj = (mem_rdata == `CDC_OP_STACK_ADJ) || (mem_rdata == `CDC_OP_INDEX_ADJ);
  // after the prefix only the two stack-relative forms exist here
  wire cur_ok_alu = cur_alu && (pfx_reg ? ((cur_hi == `CDC_HI_LONG) ||
    (cur_hi == `CDC_HI_SHORT)) : (cur_hi >= `CDC_HI_LIT));

  wire [3:0] op_hi = op_reg[7:4];
  wire op_lit = !op_reg[7] || (op_hi == `CDC_HI_LIT);
  wire [15:0] alu_out = alu(op_reg[3:0], acc_reg, mem_rdata, flags_reg);
  wire [15:0] pc_inc = wadd(pc_reg, 16'h0001);
  wire take_branch = (op_reg == `CDC_OP_BCC) ? !flags_reg[`CDC_F_C] :
    (op_reg == `CDC_OP_BCS) ? flags_reg[`CDC_F_C] : flags_reg[`CDC_F_Z];

  wire run = !stopped_reg && !bg_reg && !ill_reg && !boot_reg;

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  wire apb_wr = psel && penable && pwrite;
  wire [11:0] wa = paddr;
  wire mapped = (wa == `CDC_OFF_CTRL) || (wa == `CDC_OFF_STATUS) ||
    (wa == `CDC_OFF_FLAGS) || (wa == `CDC_OFF_ACC) || (wa == `CDC_OFF_INDEX) ||
    (wa == `CDC_OFF_STACK) || (wa == `CDC_OFF_PC);
  wire wr_ctrl = apb_wr && (wa == `CDC_OFF_CTRL);
  wire wr_flags = apb_wr && (wa == `CDC_OFF_FLAGS);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // captured in the setup cycle, so read data stands through the access
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `CDC_OFF_CTRL: prdata <= {30'h0, keep_clk_reg, dbg_en_reg};
        `CDC_OFF_STATUS: prdata <= {28'h0, osc_run, ill_reg, stopped_reg, bg_reg};
        `CDC_OFF_FLAGS: prdata <= {24'h0, flags_reg};
        `CDC_OFF_ACC: prdata <= {24'h0, acc_reg};
        `CDC_OFF_INDEX: prdata <= {16'h0, hx_reg};
        `CDC_OFF_STACK: prdata <= {16'h0, stack_ptr_reg};
        `CDC_OFF_PC: prdata <= {16'h0, pc_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power and debug outputs

  // the oscillator survives stop when the link may need it, or for wakeup
  assign osc_run = !stopped_reg || dbg_en_reg || keep_clk_reg;
  assign core_clk_en = run;
  assign bg_active = bg_reg;
  assign mem_rd = run;

  ////////////////////////////////////////////////////////////////////////
  // mode, stop and background control

  always @(posedge clk) begin
    if (!rst_b) begin
      dbg_en_reg <= 1'b0;
      keep_clk_reg <= 1'b0;
      stopped_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      bg_reg <= 1'b0;
      boot_reg <= 1'b1;
      step_pend_reg <= 1'b0;
    end else begin
      // strap caught after release, never inside the reset branch
      if (boot_reg) begin
        boot_reg <= 1'b0;
        if (bg_strap) begin
          dbg_en_reg <= 1'b1;
          bg_reg <= 1'b1;
        end
      end
      if (wr_ctrl) begin
        dbg_en_reg <= pwdata[`CDC_CTRL_DBG_EN];
        keep_clk_reg <= pwdata[`CDC_CTRL_KEEP_CLK];
      end
      if (wr_ctrl && pwdata[`CDC_CTRL_STOP])
        stop_pend_reg <= 1'b1;
      // stop is only entered on an opcode fetch, and the opcode fetched in that cycle still starts
      if (stop_pend_reg && run && state_reg == S_FETCH && !pfx_reg) begin
        stop_pend_reg <= 1'b0;
        stopped_reg <= 1'b1;
      end
      if (stopped_reg) begin
        if (dbg_bg_cmd && dbg_en_reg) begin
          stopped_reg <= 1'b0;
          bg_reg <= 1'b1;
        end else if (ext_wake || (wake_tick && keep_clk_reg)) begin
          stopped_reg <= 1'b0;
        end
      end else if (bg_reg) begin
        if (dbg_go_cmd || dbg_tag_cmd || dbg_step_cmd) begin
          bg_reg <= 1'b0;
          step_pend_reg <= dbg_step_cmd;
        end
      end else if (run && state_reg == S_FETCH) begin
        if (step_pend_reg && began_reg) begin
          bg_reg <= 1'b1;
          step_pend_reg <= 1'b0;
        end else if (mem_rdata == `CDC_OP_BG_ENTRY && !pfx_reg) begin
          bg_reg <= 1'b1;
          step_pend_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction sequencer: one bus read per cycle

  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= S_FETCH;
      pc_reg <= `CDC_RST_PC;
      mem_addr <= `CDC_RST_PC;
      acc_reg <= 8'h00;
      hx_reg <= 16'h0000;
      stack_ptr_reg <= `CDC_RST_STACK;
      flags_reg <= `CDC_RST_FLAGS;
      op_reg <= 8'h00;
      pfx_reg <= 1'b0;
      ea_hi_reg <= 8'h00;
      ill_reg <= 1'b0;
      began_reg <= 1'b0;
    end else begin
      if (!bg_reg)
        began_reg <= began_reg && !(run && state_reg == S_FETCH);
      if (run) begin
        case (state_reg)
          S_FETCH: begin
            if (step_pend_reg && began_reg) begin
              state_reg <= S_FETCH;
            end else if (!pfx_reg && mem_rdata == `CDC_OP_PREFIX) begin
              pfx_reg <= 1'b1;
              pc_reg <= pc_inc;
              mem_addr <= pc_inc;
            end else if (!pfx_reg && mem_rdata == `CDC_OP_BG_ENTRY) begin
              pc_reg <= pc_inc;
              mem_addr <= pc_inc;
            end else if (!pfx_reg && (cur_branch || cur_adj)) begin
              op_reg <= mem_rdata;
              began_reg <= 1'b1;
              pc_reg <= pc_inc;
              mem_addr <= pc_inc;
              state_reg <= S_ADR1;
            end else if (cur_ok_alu) begin
              op_reg <= mem_rdata;
              began_reg <= 1'b1;
              pc_reg <= pc_inc;
              if (cur_hi == `CDC_HI_PLAIN) begin
                mem_addr <= hx_reg;
                state_reg <= S_READ;
              end else begin
                mem_addr <= pc_inc;
                state_reg <= S_ADR1;
              end
            end else begin
              // post-increment forms belong to compare and copy ops only,
              // which this core does not carry; they trap like any unknown
              ill_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_ADR1: begin
            pc_reg <= pc_inc;
            if (op_lit) begin
              // literal operand completes here: 2 cycles in all
              mem_addr <= pc_inc;
              state_reg <= S_FETCH;
              pfx_reg <= 1'b0;
              if (op_reg == `CDC_OP_STACK_ADJ)
                stack_ptr_reg <= wadd(stack_ptr_reg, sext(mem_rdata));
              else if (op_reg == `CDC_OP_INDEX_ADJ)
                hx_reg <= wadd(hx_reg, sext(mem_rdata));
              else if (!op_reg[7]) begin
                if (take_branch) begin
                  pc_reg <= wadd(pc_inc, sext(mem_rdata));
                  mem_addr <= wadd(pc_inc, sext(mem_rdata));
                end
              end else begin
                acc_reg <= alu_out[7:0];
                flags_reg <= alu_out[15:8];
              end
            end else if (op_hi == `CDC_HI_PAGE0) begin
              mem_addr <= {8'h00, mem_rdata};
              state_reg <= S_READ;
            end else if (op_hi == `CDC_HI_SHORT) begin
              mem_addr <= wadd(pfx_reg ? stack_ptr_reg : hx_reg, {8'h00, mem_rdata});
              state_reg <= S_READ;
            end else begin
              ea_hi_reg <= mem_rdata;
              mem_addr <= pc_inc;
              state_reg <= S_ADR2;
            end
          end
          S_ADR2: begin
            pc_reg <= pc_inc;
            state_reg <= S_READ;
            if (op_hi == `CDC_HI_FULL)
              mem_addr <= {ea_hi_reg, mem_rdata};
            else
              mem_addr <= wadd(pfx_reg ? stack_ptr_reg : hx_reg, {ea_hi_reg, mem_rdata});
          end
          S_READ: begin
            acc_reg <= alu_out[7:0];
            flags_reg <= alu_out[15:8];
            mem_addr <= pc_reg;
            pfx_reg <= 1'b0;
            state_reg <= S_FETCH;
          end
          S_IDLE: state_reg <= S_IDLE;
          default: state_reg <= S_FETCH;
        endcase
      end
      if (wr_flags)
        flags_reg <= pwdata[7:0];
    end
  end

endmodule // cdc_core

`default_nettype wire

//--- logic/cdc_core_regs.vh
`ifndef CDC_CORE_REGS_VH
`define CDC_CORE_REGS_VH

// apb register byte offsets
`define CDC_OFF_CTRL 12'h000
`define CDC_OFF_STATUS 12'h004
`define CDC_OFF_FLAGS 12'h008
`define CDC_OFF_ACC 12'h00C
`define CDC_OFF_INDEX 12'h010
`define CDC_OFF_STACK 12'h014
`define CDC_OFF_PC 12'h018

// control fields
`define CDC_CTRL_DBG_EN 0
`define CDC_CTRL_KEEP_CLK 1
`define CDC_CTRL_STOP 2

// status fields
`define CDC_ST_BG 0
`define CDC_ST_STOPPED 1
`define CDC_ST_ILLEGAL 2
`define CDC_ST_OSC 3

// condition_flags bit positions
`define CDC_F_V 7
`define CDC_F_H 4
`define CDC_F_I 3
`define CDC_F_N 2
`define CDC_F_Z 1
`define CDC_F_C 0

// reset values
`define CDC_RST_FLAGS 8'h68
`define CDC_RST_STACK 16'h00FF
`define CDC_RST_PC 16'h0000

// opcodes
`define CDC_OP_PREFIX 8'h9E
`define CDC_OP_BG_ENTRY 8'h82
`define CDC_OP_STACK_ADJ 8'hA7
`define CDC_OP_INDEX_ADJ 8'hAF
`define CDC_OP_BCC 8'h24
`define CDC_OP_BCS 8'h25
`define CDC_OP_BEQ 8'h27
`define CDC_LO_ADC 4'h9
`define CDC_LO_ADD 4'hB
`define CDC_LO_AND 4'h4
`define CDC_HI_LIT 4'hA
`define CDC_HI_PAGE0 4'hB
`define CDC_HI_FULL 4'hC
`define CDC_HI_LONG 4'hD
`define CDC_HI_SHORT 4'hE
`define CDC_HI_PLAIN 4'hF

`endif

//--- tb/cdc_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cdc_core_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic bg_strap,
  input wire logic dbg_bg_cmd,
  input wire logic dbg_go_cmd,
  input wire logic dbg_step_cmd,
  input wire logic dbg_tag_cmd,
  input wire logic osc_run,
  input wire logic core_clk_en,
  input wire logic bg_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_halt; bg_active |-> !core_clk_en && !mem_rd; endproperty
  a_halt: assert property (p_halt) else $error("core runs in background");
  property p_hold;
    bg_active && !dbg_go_cmd && !dbg_step_cmd && !dbg_tag_cmd |=> bg_active; endproperty
  a_hold: assert property (p_hold) else $error("background left unasked");
  property p_go; bg_active && (dbg_go_cmd || dbg_tag_cmd) |=> !bg_active; endproperty
  a_go: assert property (p_go) else $error("resume ignored");
  property p_step; bg_active && dbg_step_cmd |=> !bg_active ##[1:8] bg_active; endproperty
  a_step: assert property (p_step) else $error("step did not come back");
  // a halted core can only reach background by the link command or the strap
  property p_noentry;
    !mem_rd && !bg_active && !dbg_bg_cmd && !bg_strap |=> !bg_active; endproperty
  a_noentry: assert property (p_noentry) else $error("background without cause");
  property p_osc; !osc_run |-> !core_clk_en && !bg_active; endproperty
  a_osc: assert property (p_osc) else $error("core active with oscillator off");
  property p_fetch; mem_rd ##1 mem_rd |-> mem_addr != $past(mem_addr); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address stuck");
  property p_park; !mem_rd ##1 !mem_rd |-> $stable(mem_addr); endproperty
  a_park: assert property (p_park) else $error("address moved while halted");
endmodule // cdc_core_asserts
bind cdc_core cdc_core_asserts i_cdc_core_asserts (.clk(clk), .rst_b(rst_b), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .bg_strap(bg_strap), .dbg_bg_cmd(dbg_bg_cmd), .dbg_go_cmd(dbg_go_cmd),
  .dbg_step_cmd(dbg_step_cmd), .dbg_tag_cmd(dbg_tag_cmd), .osc_run(osc_run),
  .core_clk_en(core_clk_en), .bg_active(bg_active));
`default_nettype wire

//--- tb/cdc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module cdc_mem_model (
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  // not read: inverse byte, so a stale value never passes for data
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
endmodule // cdc_mem_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdc_core_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bg_strap = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [5:0] pul = 6'h00;
  wire logic [31:0] prdata;
  wire logic [15:0] mem_addr;
  wire logic [7:0] mem_rdata;
  wire logic pready, pslverr, mem_rd, osc_run, core_clk_en, bg_active;
  int err_count = 0, n_checks = 0, cyc = 0;
  int tst [0:63];
  // checkpoints end each stretch with a background opcode, except the second, which ends on a single step
  logic [7:0] prog [0:37] = '{8'hAB, 8'h3F, 8'hAB, 8'hC1, 8'h82, 8'hA9, 8'h05, 8'hB9, 8'h80,
    8'h82, 8'hC4, 8'h12, 8'h34, 8'h82, 8'hAF, 8'h7F, 8'hAF, 8'hF9, 8'hA7, 8'hFF, 8'h82, 8'hFB,
    8'hEB, 8'h02, 8'hDB, 8'hFF, 8'hF8, 8'h82, 8'h9E, 8'hEB, 8'h02, 8'h9E, 8'hDB, 8'h00, 8'h03,
    8'h82, 8'h24, 8'hFE};
  logic [23:0] dat [0:6] = '{24'h0070AB, 24'h007801, 24'h007A01, 24'h00807A, 24'h1234F0,
    24'h010010, 24'h010102};
  logic [7:0] ea [0:6] = '{8'h00, 8'h06, 8'h80, 8'h80, 8'h80, 8'h2D, 8'h3F};
  logic [7:0] ef [0:6] = '{8'h7B, 8'h68, 8'hFC, 8'h7C, 8'h7C, 8'hE9, 8'h68};
  int cmd [0:6] = '{1, 0, 2, 0, 0, 0, 0};
  int pr [0:15] = '{0, 2, 2, 4, 10, 13, 21, 22, 22, 24, 24, 27, 28, 31, 31, 35};
  int dl [0:7] = '{2, 2, 4, 2, 3, 4, 4, 5};
  int wk [0:2] = '{5, 4, 3};
  cdc_core i_cdc_core (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .bg_strap(bg_strap),
    .wake_tick(pul[4]), .ext_wake(pul[5]), .dbg_bg_cmd(pul[3]), .dbg_go_cmd(pul[0]),
    .dbg_step_cmd(pul[1]), .dbg_tag_cmd(pul[2]), .osc_run(osc_run),
    .core_clk_en(core_clk_en), .bg_active(bg_active));
  cdc_mem_model i_cdc_mem_model (.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_rd === 1'b1 && mem_addr < 16'h0040) tst[mem_addr[5:0]] <= cyc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task pulse(input int b);
    @(posedge clk) pul[b] <= 1'b1;
    @(posedge clk) pul[b] <= 1'b0;
  endtask
  task wait_bg(input logic v);
    for (int i = 0; i < 300 && bg_active !== v; i++) @(posedge clk);
    `CHK(bg_active, v)
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    for (int i = 0; i < 38; i++) i_cdc_mem_model.mem[i] = prog[i];
    for (int i = 0; i < 7; i++) i_cdc_mem_model.mem[dat[i][23:8]] = dat[i][7:0];
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wait_bg(1'b1);
      apb(1'b0, `CDC_OFF_ACC, 32'h0);
      `CHK(rd, {24'h0, ea[i]})
      apb(1'b0, `CDC_OFF_FLAGS, 32'h0);
      `CHK(rd, {24'h0, ef[i]})
      if (i == 4) begin
        apb(1'b0, `CDC_OFF_INDEX, 32'h0);
        `CHK(rd, 32'h78)
        apb(1'b0, `CDC_OFF_STACK, 32'h0);
        `CHK(rd, 32'hFE)
      end
      if (i == 6) begin
        apb(1'b0, `CDC_OFF_PC, 32'h0);
        `CHK(rd, 32'h24)
        apb(1'b1, `CDC_OFF_FLAGS, 32'h6A);
        apb(1'b0, `CDC_OFF_FLAGS, 32'h0);
        `CHK(rd, 32'h6A)
      end
      pulse(cmd[i]);
      wait_bg(1'b0);
    end
    for (int i = 0; i < 8; i++) `CHK(tst[pr[2 * i + 1]] - tst[pr[2 * i]], dl[i])
    apb(1'b1, `CDC_OFF_ACC, 32'h55);
    apb(1'b0, `CDC_OFF_ACC, 32'h0);
    `CHK(rd, 32'h3F)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    // control values per pass: nothing kept, clocks kept, debug enabled
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `CDC_OFF_CTRL, (k == 1 ? 32'h2 : k == 2 ? 32'h1 : 32'h0) | 32'h4);
      rd = 32'h0;
      for (int i = 0; i < 20 && rd[`CDC_ST_STOPPED] !== 1'b1; i++)
        apb(1'b0, `CDC_OFF_STATUS, 32'h0);
      `CHK(osc_run, k != 0)
      if (k == 0) begin
        pulse(3);
        pulse(4);
        apb(1'b0, `CDC_OFF_STATUS, 32'h0);
        `CHK(rd[1:0], 2'b10)
      end
      pulse(wk[k]);
      repeat (3) @(posedge clk);
      apb(1'b0, `CDC_OFF_STATUS, 32'h0);
      `CHK(rd[1:0], {1'b0, k == 2})
      if (k == 2) pulse(0);
    end
    bg_strap <= 1'b1;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    wait_bg(1'b1);
    apb(1'b0, `CDC_OFF_CTRL, 32'h0);
    `CHK(rd[0], 1'b1)
    // prefix before the plain-index form is no encoding here: the core traps
    i_cdc_mem_model.mem[0] = 8'h9E;
    i_cdc_mem_model.mem[1] = 8'hF4;
    pulse(0);
    repeat (4) @(posedge clk);
    apb(1'b0, `CDC_OFF_STATUS, 32'h0);
    `CHK(rd[2:0], 3'b100)
    `CHK(core_clk_en, 1'b0)
    complete_run;
  end
endmodule // testbench
`default_nettype wire
